// ---- hw/bsq_burst_sequencer.sv ----
// Overview of operation
// - A counted burst emits exactly the set number of cycles per trigger, then stops and waits.
// - An infinite burst runs without a break from the moment it is triggered.
// - The burst type is counted or infinite, counted after reset.
// - Bursts start only for sine, square, ramp and pulse sources.
// - The count takes 1 to 500k with internal and 1 to 1M with manual trigger, default 1.
// - A count too large for the period lengthens the period, never the waveform frequency.
// - The burst period runs start to start, 1 us to 500 s in 1 us steps, default 10 ms.
// - The period is at least count over frequency plus 1 us, and is raised to that.
// - A start delay of 0 to 500 s in 1 ps steps, default 0, applies with manual trigger only.
// - Each burst starts at a set phase, 0 to 360 degrees in 0.001 degree steps, default 0.
// - The internal source is the default, counted mode only, one burst per period.
// - A manual command starts at once; in infinite mode it starts and stops in turn.
// - The idle level is first point, top, center, bottom or a user point.
// - The user idle point is a 16-bit value, default 0.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module bsq_burst_sequencer
    import bsq_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [bsq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [bsq_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [bsq_pkg::DATA_W-1:0] RDATA,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] WAVE_SAMPLE,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] WAVE_FIRST,
    input wire logic CYCLE_END,
    output logic WAVE_RUN,
    output logic PHASE_LOAD,
    output logic [bsq_pkg::PHASE_W-1:0] START_PHASE,
    output logic [bsq_pkg::SAMPLE_W-1:0] OUT_SAMPLE,
    output logic BURST_ACTIVE
);
    import bsq_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic enable;
    logic infinite;
    logic manual_src;
    logic [2:0] wave_type;
    logic [2:0] idle_sel;
    logic [COUNT_W-1:0] count;
    logic [PERIOD_W-1:0] period_us;
    logic [DELAY_W-1:0] delay_ps;
    logic [PHASE_W-1:0] phase;
    logic [SAMPLE_W-1:0] user_idle;
    logic [WPER_W-1:0] wave_per;
    bsq_state_t state;
    bsq_state_t next_state;
    logic manual_cmd;
    logic wave_ok;
    logic src_manual;
    logic [COUNT_W-1:0] count_eff;
    logic [CYC_W-1:0] need_cyc;
    logic [CYC_W-1:0] prog_cyc;
    logic [CYC_W-1:0] eff_period;
    logic [DELAY_W-1:0] delay_eff;
    logic [CYC_W-1:0] period_cnt;
    logic [COUNT_W-1:0] cycles_done;
    logic [DELAY_W-1:0] delay_acc;
    logic delay_done;
    logic period_due;
    logic first_due;
    logic trig;
    logic launch;
    logic finish;
    logic stop_cmd;
    logic [SAMPLE_W-1:0] idle_level;
    logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] status;

    // ----------------------------------------------------------------
    // Derived settings
    // ----------------------------------------------------------------
    // Infinite bursts only make sense on manual command
    assign src_manual = manual_src || infinite;
    assign wave_ok = (wave_type == WAVE_SINE) || (wave_type == WAVE_SQUARE)
        || (wave_type == WAVE_RAMP) || (wave_type == WAVE_PULSE);

    // Internal source caps the count lower than manual
    assign count_eff = (!src_manual && (count > COUNT_MAX_INT))
        ? COUNT_MAX_INT : count;

    // Shortest period that still fits the whole burst plus 1 us
    assign need_cyc = CYC_W'(count_eff) * CYC_W'(wave_per) + US_CYC;
    assign prog_cyc = CYC_W'(period_us) * US_CYC;

    // Too-short period is stretched; waveform rate stays as set
    assign eff_period = (prog_cyc < need_cyc)
        ? need_cyc : prog_cyc;

    // Delay exists only for the manual source
    assign delay_eff = !src_manual ? '0
        : (delay_ps > DELAY_MAX_PS) ? DELAY_MAX_PS : delay_ps;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Counted, internal, sine and first point are the reset choices
    always_ff @(posedge CLK) begin
        if (RESET) begin
            enable <= 1'b0;
            infinite <= 1'b0;
            manual_src <= 1'b0;
            wave_type <= WAVE_SINE;
            idle_sel <= IDLE_FIRST;
        end else if (WR && (ADDR == OFS_CTRL)) begin
            enable <= WDATA[CTRL_ENABLE];
            infinite <= WDATA[CTRL_INFINITE];
            manual_src <= WDATA[CTRL_MANUAL];
            wave_type <= WDATA[CTRL_WAVE_LSB +: 3];
            idle_sel <= WDATA[CTRL_IDLE_LSB +: 3];
        end
    end

    // ----------------------------------------------------------------
    // Count and period registers
    // ----------------------------------------------------------------
    // Out-of-range writes are clamped rather than rejected
    always_ff @(posedge CLK) begin
        if (RESET) begin
            count <= COUNT_DEF;
        end else if (WR && (ADDR == OFS_COUNT)) begin
            if (WDATA < DATA_W'(COUNT_MIN)) begin
                count <= COUNT_MIN;
            end else if (WDATA > DATA_W'(COUNT_MAX_MAN)) begin
                count <= COUNT_MAX_MAN;
            end else begin
                count <= WDATA[COUNT_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            period_us <= PERIOD_DEF_US;
        end else if (WR && (ADDR == OFS_PERIOD)) begin
            if (WDATA < DATA_W'(PERIOD_MIN_US)) begin
                period_us <= PERIOD_MIN_US;
            end else if (WDATA > DATA_W'(PERIOD_MAX_US)) begin
                period_us <= PERIOD_MAX_US;
            end else begin
                period_us <= WDATA[PERIOD_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Delay, phase, idle and waveform period registers
    // ----------------------------------------------------------------
    // Delay is kept in picoseconds, split over two words
    always_ff @(posedge CLK) begin
        if (RESET) begin
            delay_ps <= '0;
        end else if (WR && (ADDR == OFS_DELAY_LO)) begin
            delay_ps[DATA_W-1:0] <= WDATA;
        end else if (WR && (ADDR == OFS_DELAY_HI)) begin
            delay_ps[DELAY_W-1:DATA_W] <= WDATA[DELAY_HI_W-1:0];
        end
    end

    // Phase in thousandths of a degree
    always_ff @(posedge CLK) begin
        if (RESET) begin
            phase <= '0;
        end else if (WR && (ADDR == OFS_PHASE)) begin
            phase <= (WDATA > DATA_W'(PHASE_MAX_MDEG))
                ? PHASE_MAX_MDEG : WDATA[PHASE_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            user_idle <= '0;
        end else if (WR && (ADDR == OFS_USER_IDLE)) begin
            user_idle <= WDATA[SAMPLE_W-1:0];
        end
    end

    // Waveform period in clock cycles, set by software from frequency
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wave_per <= WPER_DEF;
        end else if (WR && (ADDR == OFS_WAVE_PER)) begin
            wave_per <= WDATA;
        end
    end

    // Manual trigger is a write-only command, one cycle wide
    assign manual_cmd = WR && (ADDR == OFS_CMD) && WDATA[CMD_TRIG];

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    // Burst period is timed from one launch to the next
    bsq_step_count #(
        .W(CYC_W),
        .STEP(CYC_W'(1))
    ) u_period (
        .clk(CLK),
        .reset(RESET),
        .clear(launch),
        .advance(1'b1),
        .value(period_cnt)
    );

    // Completed waveform cycles of the running burst
    bsq_step_count #(
        .W(COUNT_W),
        .STEP(COUNT_W'(1))
    ) u_cycles (
        .clk(CLK),
        .reset(RESET),
        .clear(launch),
        .advance((state == ST_RUN) && CYCLE_END),
        .value(cycles_done)
    );

    // Elapsed delay in picoseconds, one clock period per edge
    bsq_step_count #(
        .W(DELAY_W),
        .STEP(CLK_STEP_PS)
    ) u_delay (
        .clk(CLK),
        .reset(RESET),
        .clear(state != ST_HOLD),
        .advance(1'b1),
        .value(delay_acc)
    );

    // ----------------------------------------------------------------
    // Trigger sources
    // ----------------------------------------------------------------
    // First internal burst goes out as soon as the block is enabled
    always_ff @(posedge CLK) begin
        if (RESET) begin
            first_due <= 1'b1;
        end else if (!enable) begin
            first_due <= 1'b1;
        end else if (launch) begin
            first_due <= 1'b0;
        end
    end

    assign period_due = first_due || (period_cnt >= eff_period - CYC_W'(1));

    // Internal timer fires once per period; manual fires on command
    assign trig = enable && wave_ok && (src_manual
        ? manual_cmd : period_due);

    // Second command in infinite mode halts the run or its delay
    assign stop_cmd = enable && infinite && manual_cmd;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign delay_done = (delay_acc + CLK_STEP_PS >= delay_eff);
    assign launch = ((state == ST_WAIT) && trig && (delay_eff == '0))
        || ((state == ST_HOLD) && enable && !stop_cmd && delay_done);
    assign finish = !infinite && CYCLE_END
        && (cycles_done >= count_eff - COUNT_W'(1));

    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (trig) begin
                    next_state = (delay_eff == '0) ? ST_RUN : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!enable || stop_cmd) begin
                    next_state = ST_WAIT;
                end else if (delay_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // Triggers are not looked at here, so none can restart
                if (!enable || stop_cmd) begin
                    next_state = ST_WAIT;
                end else if (finish) begin
                    next_state = ST_WAIT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_WAIT;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Waveform control outputs
    // ----------------------------------------------------------------
    // Phase is loaded on the launch edge so the first sample is right
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PHASE_LOAD <= 1'b0;
            START_PHASE <= '0;
            WAVE_RUN <= 1'b0;
            BURST_ACTIVE <= 1'b0;
        end else begin
            PHASE_LOAD <= launch;
            START_PHASE <= phase;
            WAVE_RUN <= (next_state == ST_RUN);
            BURST_ACTIVE <= (next_state == ST_RUN);
        end
    end

    bsq_idle_pick u_idle (
        .select(idle_sel),
        .first_sample(WAVE_FIRST),
        .user_level(user_idle),
        .level(idle_level)
    );

    // Waveform passes only while running; idle level otherwise
    always_ff @(posedge CLK) begin
        if (RESET) begin
            OUT_SAMPLE <= LVL_BOTTOM;
        end else begin
            OUT_SAMPLE <= (state == ST_RUN)
                ? WAVE_SAMPLE : idle_level;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign status = {{(DATA_W-ST_SHOWN){1'b0}}, infinite, !wave_ok,
        (state == ST_HOLD), (state == ST_RUN)};

    always_comb begin
        case (ADDR)
            OFS_CTRL: read_mux = {{(DATA_W-CTRL_IDLE_LSB-3){1'b0}}, idle_sel,
                1'b0, wave_type, 1'b0, manual_src, infinite, enable};
            OFS_COUNT: read_mux = DATA_W'(count);
            OFS_PERIOD: read_mux = DATA_W'(period_us);
            OFS_DELAY_LO: read_mux = delay_ps[DATA_W-1:0];
            OFS_DELAY_HI: read_mux = DATA_W'(delay_ps[DELAY_W-1:DATA_W]);
            OFS_PHASE: read_mux = DATA_W'(phase);
            OFS_USER_IDLE: read_mux = DATA_W'(user_idle);
            OFS_WAVE_PER: read_mux = wave_per;
            OFS_STATUS: read_mux = status;
            OFS_EFF_LO: read_mux = eff_period[DATA_W-1:0];
            OFS_EFF_HI: read_mux = DATA_W'(eff_period[CYC_W-1:DATA_W]);
            default: read_mux = '0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= '0;
        end else begin
            RDATA <= RD ? read_mux : '0;
        end
    end

endmodule // bsq_burst_sequencer

// ---- hw/bsq_idle_pick.sv ----
`timescale 1ns/1ps
// Chooses the level held on the output between bursts
module bsq_idle_pick
    import bsq_pkg::*;
(
    input wire logic [2:0] select,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] first_sample,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] user_level,
    output logic [bsq_pkg::SAMPLE_W-1:0] level
);

    // ----------------------------------------------------------------
    // Level mux
    // ----------------------------------------------------------------
    // Unknown codes fall back to the first point, the reset choice
    always_comb begin
        case (select)
            IDLE_TOP: level = LVL_TOP;
            IDLE_CENTER: level = LVL_CENTER;
            IDLE_BOTTOM: level = LVL_BOTTOM;
            IDLE_USER: level = user_level;
            default: level = first_sample;
        endcase
    end

endmodule // bsq_idle_pick

// ---- hw/bsq_pkg.sv ----
package bsq_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_DELAY_LO = 8'h10;
    localparam logic [7:0] OFS_DELAY_HI = 8'h14;
    localparam logic [7:0] OFS_PHASE = 8'h18;
    localparam logic [7:0] OFS_USER_IDLE = 8'h1C;
    localparam logic [7:0] OFS_WAVE_PER = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_EFF_LO = 8'h28;
    localparam logic [7:0] OFS_EFF_HI = 8'h2C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_INFINITE = 1;
    localparam int CTRL_MANUAL = 2;
    localparam int CTRL_WAVE_LSB = 4;
    localparam int CTRL_IDLE_LSB = 8;
    localparam int CMD_TRIG = 0;
    localparam int ST_ACTIVE = 0;
    localparam int ST_DELAY = 1;
    localparam int ST_BADWAVE = 2;
    localparam int ST_INFINITE = 3;
    localparam int ST_SHOWN = 4;

    // ----------------------------------------------------------------
    // Field widths
    // ----------------------------------------------------------------
    localparam int COUNT_W = 20;
    localparam int PERIOD_W = 29;
    localparam int DELAY_W = 49;
    localparam int DELAY_HI_W = DELAY_W - DATA_W;
    localparam int PHASE_W = 19;
    localparam int SAMPLE_W = 16;
    localparam int WPER_W = 32;
    localparam int CYC_W = 52;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint CLK_PERIOD_PS = 10000;
    localparam longint US_PS = 1000000;
    localparam longint US_CYC_L = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [CYC_W-1:0] US_CYC = CYC_W'(US_CYC_L);
    localparam logic [DELAY_W-1:0] CLK_STEP_PS = DELAY_W'(CLK_PERIOD_PS);

    // ----------------------------------------------------------------
    // Limits and reset values
    // ----------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_MIN = 20'h0_0001;
    localparam logic [COUNT_W-1:0] COUNT_MAX_INT = COUNT_W'(500000);
    localparam logic [COUNT_W-1:0] COUNT_MAX_MAN = COUNT_W'(1000000);
    localparam logic [COUNT_W-1:0] COUNT_DEF = 20'h0_0001;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN_US = 29'h0000_0001;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX_US = PERIOD_W'(500000000);
    localparam logic [PERIOD_W-1:0] PERIOD_DEF_US = PERIOD_W'(10000);
    localparam logic [DELAY_W-1:0] DELAY_MAX_PS = 49'h1_C6BF_5263_4000;
    localparam logic [PHASE_W-1:0] PHASE_MAX_MDEG = PHASE_W'(360000);
    localparam logic [WPER_W-1:0] WPER_DEF = 32'h0001_86A0;
    localparam logic [SAMPLE_W-1:0] LVL_TOP = 16'hFFFF;
    localparam logic [SAMPLE_W-1:0] LVL_CENTER = 16'h8000;
    localparam logic [SAMPLE_W-1:0] LVL_BOTTOM = 16'h0000;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        WAVE_SINE = 3'h0,
        WAVE_SQUARE = 3'h1,
        WAVE_RAMP = 3'h2,
        WAVE_PULSE = 3'h3,
        WAVE_NOISE = 3'h4
    } bsq_wave_t;

    typedef enum logic [2:0] {
        IDLE_FIRST = 3'h0,
        IDLE_TOP = 3'h1,
        IDLE_CENTER = 3'h2,
        IDLE_BOTTOM = 3'h3,
        IDLE_USER = 3'h4
    } bsq_idle_t;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } bsq_state_t;

endpackage

// ---- hw/bsq_step_count.sv ----
`timescale 1ns/1ps
// Up-counter that adds a fixed step; clear beats advance
module bsq_step_count #(
    parameter int W = 32,
    parameter logic [W-1:0] STEP = W'(1)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic advance,
    output logic [W-1:0] value
);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Saturates so a stalled run never wraps into a false match
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            value <= '0;
        end else if (advance && (value <= ~STEP)) begin
            value <= value + STEP;
        end
    end

endmodule // bsq_step_count

// ---- verif/bsq_burst_sequencer_props.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks of the burst sequencer
// ------------------------------------------------------------
module bsq_burst_sequencer_props
    import bsq_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic WR,
    input wire logic RD,
    input wire logic [bsq_pkg::DATA_W-1:0] RDATA,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] WAVE_SAMPLE,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] WAVE_FIRST,
    input wire logic CYCLE_END,
    input wire logic WAVE_RUN,
    input wire logic PHASE_LOAD,
    input wire logic [bsq_pkg::PHASE_W-1:0] START_PHASE,
    input wire logic [bsq_pkg::SAMPLE_W-1:0] OUT_SAMPLE,
    input wire logic BURST_ACTIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // Launch, run, idle and read data relations
    AST_ACTIVE_RUN: assert property (
        BURST_ACTIVE == WAVE_RUN) else $error("active differs from run");
    AST_LOAD_AT_START: assert property (
        $rose(WAVE_RUN) |-> PHASE_LOAD) else $error("no phase load");
    AST_LOAD_PULSE: assert property (
        PHASE_LOAD |=> !PHASE_LOAD) else $error("phase load too long");
    AST_PHASE_RANGE: assert property (
        START_PHASE <= PHASE_MAX_MDEG) else $error("phase out of range");
    AST_OUT_FOLLOWS: assert property (
        $past(WAVE_RUN) |-> OUT_SAMPLE == $past(WAVE_SAMPLE))
        else $error("output not following source");
    AST_STOP_CAUSE: assert property (
        $fell(WAVE_RUN) |-> $past(CYCLE_END) || $past(WR) || $past(WR, 2))
        else $error("run stopped without cause");
    // Idle level may only move after a write, a run, a reset or a change of the first point
    AST_IDLE_HOLD: assert property (
        !$past(WAVE_RUN) && !$past(WAVE_RUN, 2) && !$past(WR)
        && !$past(WR, 2) && !$past(RESET) && !$past(RESET, 2)
        && $past(WAVE_FIRST) == $past(WAVE_FIRST, 2)
        |-> $stable(OUT_SAMPLE)) else $error("idle level moved");
    AST_RDATA_ZERO: assert property (
        !$past(RD) |-> RDATA == '0) else $error("read data not cleared");

    cover property ($rose(WAVE_RUN));
    cover property (CYCLE_END && WAVE_RUN);
    cover property ($fell(WAVE_RUN));
endmodule // bsq_burst_sequencer_props

bind bsq_burst_sequencer bsq_burst_sequencer_props u_props (
    .CLK, .RESET, .WR, .RD, .RDATA, .WAVE_SAMPLE, .WAVE_FIRST,
    .CYCLE_END, .WAVE_RUN, .PHASE_LOAD, .START_PHASE, .OUT_SAMPLE,
    .BURST_ACTIVE
);

// ---- verif/bsq_wave_src.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Waveform source model, L clocks per waveform cycle
// ------------------------------------------------------------
module bsq_wave_src #(
    parameter int L = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic phase_load,
    output logic [15:0] sample,
    output logic [15:0] first,
    output logic cycle_end
);
    logic [15:0] pos;
    logic [15:0] junk;

    // Position restarts on phase load, advances only while running
    always_ff @(posedge clk) begin
        if (reset) begin
            pos <= 16'h0000;
            junk <= 16'hA5A5;
        end else begin
            junk <= ~junk;
            if (phase_load) begin
                pos <= 16'h0000;
            end else if (run) begin
                pos <= (pos == 16'(L - 1)) ? 16'h0000 : pos + 16'h0001;
            end
        end
    end

    // Stopped source shows a toggling pattern, never a frozen value
    assign sample = run ? 16'h1000 + pos : junk;
    assign first = 16'h0ABC;
    assign cycle_end = run && !phase_load && pos == 16'(L - 1);
endmodule // bsq_wave_src

// ---- verif/test_bsq_burst_sequencer.sv ----
`timescale 1ns/1ps
module test_bsq_burst_sequencer;
    import bsq_pkg::*;
    localparam int L = 4;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA, d;
    logic [15:0] WAVE_SAMPLE, WAVE_FIRST, OUT_SAMPLE;
    logic CYCLE_END, WAVE_RUN, PHASE_LOAD, BURST_ACTIVE;
    logic [18:0] START_PHASE;
    logic [15:0] lvl [4] = '{16'h0ABC, LVL_TOP, LVL_CENTER, LVL_BOTTOM};
    int n_fail = 0;
    int check_count = 0;
    int len, ends, first, p;

    bsq_burst_sequencer dut (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD,
        .RDATA, .WAVE_SAMPLE, .WAVE_FIRST, .CYCLE_END, .WAVE_RUN,
        .PHASE_LOAD, .START_PHASE, .OUT_SAMPLE, .BURST_ACTIVE);
    bsq_wave_src #(.L(L)) src (.clk(CLK), .reset(RESET), .run(WAVE_RUN),
        .phase_load(PHASE_LOAD), .sample(WAVE_SAMPLE),
        .first(WAVE_FIRST), .cycle_end(CYCLE_END));

    // ------------------------------------------------------------
    // Clock, bus tasks and compare
    // ------------------------------------------------------------
    initial forever #5 CLK = ~CLK;

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(n, e, RDATA);
    endtask

    // Fire a trigger, then watch 150 cycles; optional retrigger
    task burst(input int retrig);
        len = 0;
        ends = 0;
        first = -1;
        wr(OFS_CMD, 32'h0000_0001);
        for (int i = 0; i < 150; i++) begin
            #1;
            if (WAVE_RUN === 1'b1) begin
                len++;
                if (first < 0) first = i;
            end
            if (CYCLE_END === 1'b1 && WAVE_RUN === 1'b1) ends++;
            @(posedge CLK);
            WR <= (retrig != 0 && i == 3);
        end
    endtask

    // Spacing of the last two launches
    task per();
        int r1;
        r1 = 0;
        for (int i = 0; i < 600; i++) begin
            @(posedge CLK);
            #1 if (PHASE_LOAD === 1'b1) begin
                p = i - r1;
                r1 = i;
            end
        end
    endtask

    task summarize;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog sized well beyond the expected run
    initial begin
        #500000;
        n_fail++;
        summarize;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        rc("ctrl", OFS_CTRL, 32'h0000_0000);
        rc("count", OFS_COUNT, 32'h0000_0001);
        rc("period", OFS_PERIOD, 32'h0000_2710);
        rc("delay", OFS_DELAY_LO, 32'h0000_0000);
        rc("phase", OFS_PHASE, 32'h0000_0000);
        rc("user", OFS_USER_IDLE, 32'h0000_0000);
        rc("unmapped", 8'h30, 32'h0000_0000);
        wr(OFS_COUNT, 32'h0000_0000);
        rc("count lo", OFS_COUNT, 32'h0000_0001);
        wr(OFS_COUNT, 32'h001E_8480);
        rc("count hi", OFS_COUNT, 32'h000F_4240);
        wr(OFS_PHASE, 32'h0006_1A80);
        rc("phase hi", OFS_PHASE, 32'h0005_7E40);
        wr(OFS_PERIOD, 32'h0000_0000);
        rc("period lo", OFS_PERIOD, 32'h0000_0001);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CTRL, 32'(s) << CTRL_IDLE_LSB);
            repeat (3) @(posedge CLK);
            #1 chk("idle", {16'h0000, lvl[s]}, {16'h0000, OUT_SAMPLE});
        end
        wr(OFS_WAVE_PER, 32'(L));
        wr(OFS_PHASE, 32'h0000_04D2);
        wr(OFS_USER_IDLE, 32'h0000_5A5A);
        wr(OFS_COUNT, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0405);
        burst(1);
        chk("len", 32'(3 * L + 1), 32'(len));
        chk("ends", 32'h0000_0003, 32'(ends));
        chk("start", 32'h0000_04D2, 32'(START_PHASE));
        chk("user", 32'h0000_5A5A, 32'(OUT_SAMPLE));
        wr(OFS_COUNT, 32'h0000_0001);
        for (int w = 0; w < 5; w++) begin
            wr(OFS_CTRL, 32'h0000_0405 | (32'(w) << CTRL_WAVE_LSB));
            burst(0);
            chk("wave", (w < 4) ? 32'(L + 1) : 32'h0, 32'(len));
        end
        wr(OFS_CTRL, 32'h0000_0405);
        wr(OFS_DELAY_LO, 32'h0000_C350);
        burst(0);
        chk("delay", 32'h0000_0005, 32'(first));
        wr(OFS_DELAY_LO, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0003);
        burst(0);
        chk("endless", 32'h0000_0096, 32'(len));
        rc("status", OFS_STATUS, 32'h0000_0009);
        wr(OFS_CMD, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        #1 chk("stop", 32'h0000_0000, 32'(WAVE_RUN));
        wr(OFS_CTRL, 32'h0000_0001);
        per();
        chk("min period", 32'h0000_0068, 32'(p));
        rc("eff", OFS_EFF_LO, 32'h0000_0068);
        wr(OFS_COUNT, 32'h0000_001E);
        per();
        chk("stretch", 32'h0000_00DC, 32'(p));
        summarize;
    end
endmodule // test_bsq_burst_sequencer
